// ===== inc/standby_pkg.sv
package standby_pkg;
   // ------------------------------------------------------------
   // register map (word byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] addr_clock_control = 4'h0;
   localparam logic [3:0] addr_wait_select   = 4'h4;
   localparam logic [3:0] addr_irq_request   = 4'h8;
   localparam logic [3:0] addr_irq_enable    = 4'hC;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int stop_bit      = 3;
   localparam int halt_bit      = 2;
   localparam int bypass_bit    = 2;
   localparam int key_src       = 3;
   localparam int timer_src     = 0;
   localparam int irq0_src      = 1;
   // ------------------------------------------------------------
   // reset values and wait exponents
   // ------------------------------------------------------------
   localparam logic [3:0] clock_control_reset = 4'h0;
   localparam logic [3:0] wait_select_reset   = 4'h0;
   localparam int wait_exp_000 = 20;
   localparam int wait_exp_011 = 17;
   localparam int wait_exp_101 = 15;
   localparam int wait_exp_111 = 13;
   localparam int reset_wait_exp_long  = 17;
   localparam int reset_wait_exp_short = 15;
   localparam int osc_start_cycles     = 16;
   typedef enum logic [2:0] {st_run, st_halt, st_stop, st_osc_start, st_wait} standby_type;
endpackage

// ===== rtl/wait_counter.sv
`timescale 1ns/1ps
module wait_counter
   import standby_pkg::*;
#(
   parameter int width = 21
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             nrst,
   // control
   input  wire logic             start,
   input  wire logic [width-1:0] limit,
   // status
   output logic                  done
);
   logic [width-1:0] count;
   logic             busy;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         count <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else if (start) begin
         count <= '0;
         busy  <= 1'b1;
         done  <= 1'b0;
      end else if (busy) begin
         if (count == limit) begin
            busy <= 1'b0;
            done <= 1'b1;
         end else begin
            count <= count + 1'b1;
         end
      end else begin
         done <= 1'b0;
      end
   end
endmodule

// ===== rtl/standby_mode_controller.sv
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
// Contract
// - stop halts oscillator, cpu, interval timer and timer counters
// - halt gates only cpu clock; oscillator and timers keep running
// - standby keeps all registers, flags, memory and port latches
// - stop instruction sets control bit 3, halt sets bit 2
// - interval timer runs in halt; interval flag or watchdog reset
// - irq zero in standby only with filter bypassed; key test on falling edge
// - reset or enabled interrupt request releases stop and halt
// - key fall with return enable pin high releases stop by reset
// - key return reset ignores interrupt enable flags
// - enabled pending request at entry releases halt immediately
// - stop with pending request goes to halt, waits, resumes
// - enabled request during stop enters halt, waits, then runs
// - wait select low bits pick 2^20, 2^17, 2^15 or 2^13 periods
// - wait count starts only after oscillator restarts
// - reset release wait is build option 2^17 or 2^15
// - disabled sources never release stop; key return reset still does
// - external reset clears both flags; key reset sets key flag
// - master enable decides vectored interrupt after two instructions
// - key fall in stop with enable pin low gives no reset
module standby_mode_controller
   import standby_pkg::*;
#(
   parameter bit long_reset_wait = 1'b1,
   parameter int wait_scale      = 0
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // cpu side
   input  wire logic        stop_exec,
   input  wire logic        halt_exec,
   input  wire logic        master_interrupt_enable,
   input  wire logic        watchdog_timer_mode,
   input  wire logic        timer_overflow,
   input  wire logic        timer_tick,
   input  wire logic        noise_filter_bypass_bit,
   // pins
   input  wire logic        external_irq_zero,
   input  wire logic [3:0]  key_input_pin,
   input  wire logic        key_return_reset_enable_pin,
   // outputs
   output logic             osc_enable,
   output logic             cpu_clock_enable,
   output logic             timers_enable,
   output logic             system_reset,
   output logic             vector_request,
   output logic             key_return_flag,
   output logic             watchdog_flag
);
   // ------------------------------------------------------------
   // registers and state
   // ------------------------------------------------------------
   standby_type      state;
   logic [3:0]       processor_clock_control;
   logic [3:0]       standby_wait_select;
   logic [3:0]       irq_request;
   logic [3:0]       int_enable_flag;
   logic [3:0]       key_s1, key_s2, key_prev;
   logic [3:0]       req_set, req_clear;
   logic             krr_s1, krr_s2, irq0_s1, irq0_s2, irq0_prev;
   logic             key_fall, irq0_fall, pending, reset_release;
   logic [21:0]      wait_limit;
   logic             wait_start, wait_done;
   logic [4:0]       osc_count;
   logic             bus_ack;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         key_s1 <= 4'hF;
         key_s2 <= 4'hF;
         key_prev <= 4'hF;
         krr_s1 <= 1'b0;
         krr_s2 <= 1'b0;
         irq0_s1 <= 1'b1;
         irq0_s2 <= 1'b1;
         irq0_prev <= 1'b1;
      end else begin
         key_s1 <= key_input_pin;
         key_s2 <= key_s1;
         key_prev <= key_s2;
         krr_s1 <= key_return_reset_enable_pin;
         krr_s2 <= krr_s1;
         irq0_s1 <= external_irq_zero;
         irq0_s2 <= irq0_s1;
         irq0_prev <= irq0_s2;
      end
   end

   // key falling edge
   // a low key pin masks the other pins' falls
   assign key_fall  = (&key_prev) && !(&key_s2);
   assign irq0_fall = irq0_prev && !irq0_s2 && (state == st_run || noise_filter_bypass_bit);
   assign pending   = |(irq_request & int_enable_flag);

   // ------------------------------------------------------------
   // bus slave: one wait cycle per access
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         // idles high, so every access waits exactly one cycle
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            unique case (avs_address)
               addr_clock_control: avs_readdata <= {28'h0, processor_clock_control};
               addr_wait_select:   avs_readdata <= {28'h0, standby_wait_select};
               addr_irq_request:   avs_readdata <= {28'h0, irq_request};
               addr_irq_enable:    avs_readdata <= {28'h0, int_enable_flag};
               default:            avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign bus_ack = !avs_waitrequest;

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         processor_clock_control <= clock_control_reset;
         standby_wait_select <= wait_select_reset;
         int_enable_flag <= 4'h0;
      end else begin
         if (avs_write && bus_ack && avs_address == addr_wait_select) begin
            standby_wait_select <= avs_writedata[3:0];
         end
         if (avs_write && bus_ack && avs_address == addr_irq_enable) begin
            int_enable_flag <= avs_writedata[3:0];
         end
         if (avs_write && bus_ack && avs_address == addr_clock_control) begin
            processor_clock_control[1:0] <= avs_writedata[1:0];
         end
         if (stop_exec) begin
            processor_clock_control[stop_bit] <= 1'b1;
         end else if (halt_exec) begin
            processor_clock_control[halt_bit] <= 1'b1;
         end else if (state == st_run) begin
            processor_clock_control[3:2] <= 2'b00;
         end
      end
   end

   // request flags: set wins over software clear
   // interval, irq zero and key flag sets
   always_comb begin
      req_set = 4'h0;
      req_set[timer_src] = timer_tick && timers_enable && !watchdog_timer_mode;
      req_set[irq0_src] = irq0_fall;
      req_set[key_src] = key_fall;
   end
   assign req_clear = (avs_write && bus_ack && avs_address == addr_irq_request)
                      ? avs_writedata[3:0] : 4'h0;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         irq_request <= 4'h0;
      end else begin
         irq_request <= req_set | (irq_request & ~req_clear);
      end
   end

   // ------------------------------------------------------------
   // wait selection
   // ------------------------------------------------------------
   always_comb begin
      wait_limit = '0;
      if (reset_release) begin
         wait_limit[(long_reset_wait ? reset_wait_exp_long : reset_wait_exp_short)
                    - wait_scale] = 1'b1;
      end else begin
         unique case (standby_wait_select[2:0])
            3'h3:    wait_limit[wait_exp_011 - wait_scale] = 1'b1;
            3'h5:    wait_limit[wait_exp_101 - wait_scale] = 1'b1;
            3'h7:    wait_limit[wait_exp_111 - wait_scale] = 1'b1;
            default: wait_limit[wait_exp_000 - wait_scale] = 1'b1;
         endcase
      end
   end

   wait_counter #(.width(22)) u_wait (
      .mclk  (mclk),
      .nrst  (nrst),
      .start (wait_start),
      .limit (wait_limit - 22'h1),
      .done  (wait_done)
   );

   // ------------------------------------------------------------
   // standby sequencer
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state <= st_run;
         osc_count <= 5'h0;
         wait_start <= 1'b0;
         reset_release <= 1'b0;
         system_reset <= 1'b0;
      end else begin
         wait_start <= 1'b0;
         system_reset <= 1'b0;
         unique case (state)
            st_run: begin
               // stop with pending goes halt and waits
               if (stop_exec && pending) begin
                  state <= st_wait;
                  reset_release <= 1'b0;
                  wait_start <= 1'b1;
               end else if (stop_exec) begin
                  state <= st_stop;
               end else if (halt_exec && !pending) begin
                  state <= st_halt;
               end
            end
            st_halt: begin
               if (watchdog_timer_mode && timer_overflow) begin
                  system_reset <= 1'b1;
                  state <= st_run;
               end else if (pending) begin
                  state <= st_run;
               end
            end
            st_stop: begin
               if (key_fall && krr_s2) begin
                  reset_release <= 1'b1;
                  state <= st_osc_start;
                  osc_count <= 5'h0;
               end else if (pending) begin
                  reset_release <= 1'b0;
                  state <= st_osc_start;
                  osc_count <= 5'h0;
               end
            end
            st_osc_start: begin
               if (osc_count == 5'(osc_start_cycles - 1)) begin
                  state <= st_wait;
                  wait_start <= 1'b1;
               end else begin
                  osc_count <= osc_count + 5'h1;
               end
            end
            st_wait: begin
               if (wait_done) begin
                  state <= st_run;
                  system_reset <= reset_release;
               end
            end
            default: state <= st_run;
         endcase
      end
   end

   // ------------------------------------------------------------
   // clock gating and flags
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         osc_enable <= 1'b1;
         cpu_clock_enable <= 1'b1;
         timers_enable <= 1'b1;
         vector_request <= 1'b0;
      end else begin
         osc_enable <= (state != st_stop);
         timers_enable <= (state != st_stop) && (state != st_osc_start);
         cpu_clock_enable <= (state == st_run);
         vector_request <= master_interrupt_enable && state == st_run
                           && |(irq_request & int_enable_flag & ~(4'h1 << key_src));
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         key_return_flag <= 1'b0;
         watchdog_flag <= 1'b0;
      end else if (state == st_wait && wait_done && reset_release) begin
         key_return_flag <= 1'b1;
      end else if (state == st_halt && watchdog_timer_mode && timer_overflow) begin
         watchdog_flag <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_stop_osc;
      @(posedge mclk) disable iff (!nrst) (state == st_stop) |=> !osc_enable;
   endproperty
   a_stop_osc: assert property (p_stop_osc) else $error("osc runs in stop");
   property p_halt_osc;
      @(posedge mclk) disable iff (!nrst) (state == st_halt) |=> osc_enable && !cpu_clock_enable;
   endproperty
   a_halt_osc: assert property (p_halt_osc) else $error("halt gating wrong");
   property p_stop_bit;
      @(posedge mclk) disable iff (!nrst) stop_exec |=> processor_clock_control[stop_bit];
   endproperty
   a_stop_bit: assert property (p_stop_bit) else $error("stop bit not set");
   property p_pending_stop;
      @(posedge mclk) disable iff (!nrst) (state == st_run && stop_exec && pending) |=> state == st_wait;
   endproperty
   a_pending_stop: assert property (p_pending_stop) else $error("stop not bypassed");
   property p_no_release;
      @(posedge mclk) disable iff (!nrst)
         (state == st_stop && !pending && !(key_fall && krr_s2)) |=> state == st_stop;
   endproperty
   a_no_release: assert property (p_no_release) else $error("spurious stop release");
   property p_key_reset;
      @(posedge mclk) disable iff (!nrst) (state == st_stop && key_fall && krr_s2) |=> state == st_osc_start;
   endproperty
   a_key_reset: assert property (p_key_reset) else $error("key reset missed");
   property p_osc_first;
      @(posedge mclk) disable iff (!nrst) (state == st_stop) ##1 (state == st_osc_start) |-> !wait_start;
   endproperty
   a_osc_first: assert property (p_osc_first) else $error("wait before osc");
   property p_halt_release;
      @(posedge mclk) disable iff (!nrst) (state == st_halt && pending) |=> state == st_run;
   endproperty
   a_halt_release: assert property (p_halt_release) else $error("halt not released");
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top
   import standby_pkg::*;
;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        stop_exec = 1'b0;
   logic        halt_exec = 1'b0;
   logic        master_interrupt_enable = 1'b0;
   logic        watchdog_timer_mode = 1'b0;
   logic        timer_overflow = 1'b0;
   logic        timer_tick = 1'b0;
   logic        noise_filter_bypass_bit = 1'b0;
   logic        external_irq_zero = 1'b1;
   logic [3:0]  key_input_pin = 4'hF;
   logic        key_return_reset_enable_pin = 1'b0;
   logic        osc_enable, cpu_clock_enable, timers_enable, system_reset;
   logic        vector_request, key_return_flag, watchdog_flag;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          rst_seen = 0;
   int          vec_seen = 0;
   int          n;
   logic [31:0] rd;
   // sim scale: exponents drop by 10, reset wait 2^7
   localparam int scale = 10;
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (system_reset === 1'b1) rst_seen++;
      if (vector_request === 1'b1) vec_seen++;
   end
   standby_mode_controller #(.long_reset_wait(1'b1), .wait_scale(scale)) DUT (
      .mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .stop_exec(stop_exec), .halt_exec(halt_exec),
      .master_interrupt_enable(master_interrupt_enable),
      .watchdog_timer_mode(watchdog_timer_mode), .timer_overflow(timer_overflow),
      .timer_tick(timer_tick), .noise_filter_bypass_bit(noise_filter_bypass_bit),
      .external_irq_zero(external_irq_zero), .key_input_pin(key_input_pin),
      .key_return_reset_enable_pin(key_return_reset_enable_pin),
      .osc_enable(osc_enable), .cpu_clock_enable(cpu_clock_enable),
      .timers_enable(timers_enable), .system_reset(system_reset),
      .vector_request(vector_request), .key_return_flag(key_return_flag),
      .watchdog_flag(watchdog_flag));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // hold request until waitrequest seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin miscompares++; stop_test(); end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      rd = avs_readdata;
      @(posedge mclk);
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge mclk);
   endtask
   // wait in cycles for a wait-select code; prohibited codes act as the longest
   function automatic int wait_cycles(input logic [2:0] code);
      int e;
      case (code)
         3'h3:    e = wait_exp_011;
         3'h5:    e = wait_exp_101;
         3'h7:    e = wait_exp_111;
         default: e = wait_exp_000;
      endcase
      return 1 << (e - scale);
   endfunction
   task automatic wait_cpu();
      n = 0;
      while (cpu_clock_enable !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 3000) begin miscompares++; stop_test(); end
   endtask
   task automatic key_fall();
      key_input_pin <= ~(4'h1 << ($urandom % 4));
      @(posedge mclk);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int codes [4] = '{0, 3, 5, 7};
      logic [31:0] v;
      int w;
      void'($urandom(32'h6d7d));
      cyc(5);
      nrst <= 1'b1;
      @(posedge mclk);
      `CHK({osc_enable, cpu_clock_enable, timers_enable}, 3'b111)
      `CHK({system_reset, key_return_flag, watchdog_flag}, 3'b000)
      bus(0, addr_clock_control, 0); `CHK(rd[3:0], clock_control_reset)
      bus(0, addr_wait_select, 0);   `CHK(rd[3:0], wait_select_reset)
      bus(0, 4'h2, 0);               `CHK(rd, 32'h0)
      // registers hold what was written, unmapped space reads zero
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         bus(1, addr_wait_select, v);
         bus(1, 4'h6, ~v);
         bus(0, addr_wait_select, 0); `CHK(rd[3:0], v[3:0])
         bus(1, addr_clock_control, v);
         bus(0, addr_clock_control, 0); `CHK(rd[1:0], v[1:0])
         bus(0, 4'h6, 0); `CHK(rd, 32'h0)
      end
      $display("test registers done");
      bus(1, addr_irq_enable, 0);
      bus(1, addr_irq_request, 32'hF);
      halt_exec <= 1'b1; @(posedge mclk); halt_exec <= 1'b0; cyc(3);
      `CHK({osc_enable, cpu_clock_enable, timers_enable}, 3'b101)
      bus(0, addr_clock_control, 0); `CHK(rd[halt_bit], 1'b1)
      timer_tick <= 1'b1; @(posedge mclk); timer_tick <= 1'b0; cyc(10);
      bus(0, addr_irq_request, 0); `CHK(rd[timer_src], 1'b1)
      `CHK(cpu_clock_enable, 1'b0)
      master_interrupt_enable <= 1'b1;
      vec_seen = 0;
      bus(1, addr_irq_enable, 32'h1 << timer_src);
      wait_cpu(); cyc(50);
      `CHK(vec_seen > 0, 1'b1)
      master_interrupt_enable <= 1'b0;
      bus(1, addr_irq_enable, 0);
      bus(1, addr_irq_request, 32'hF);
      watchdog_timer_mode <= 1'b1;
      halt_exec <= 1'b1; @(posedge mclk); halt_exec <= 1'b0; cyc(3);
      rst_seen = 0;
      timer_overflow <= 1'b1; @(posedge mclk); timer_overflow <= 1'b0;
      wait_cpu(); cyc(5);
      `CHK({rst_seen > 0, watchdog_flag}, 2'b11)
      watchdog_timer_mode <= 1'b0;
      $display("test halt done");
      // stop; disabled or filtered sources must not release
      bus(1, addr_irq_enable, 0);
      bus(1, addr_irq_request, 32'hF);
      bus(1, addr_irq_enable, 32'h2);
      stop_exec <= 1'b1; @(posedge mclk); stop_exec <= 1'b0; cyc(5);
      `CHK({osc_enable, cpu_clock_enable, timers_enable}, 3'b000)
      bus(0, addr_clock_control, 0); `CHK(rd[stop_bit], 1'b1)
      external_irq_zero <= 1'b0; cyc(60);
      `CHK({osc_enable, cpu_clock_enable}, 2'b00)
      external_irq_zero <= 1'b1;
      bus(1, addr_irq_enable, 0);
      rst_seen = 0;
      key_fall(); cyc(60);
      `CHK({rst_seen > 0, cpu_clock_enable}, 2'b00)
      key_input_pin <= 4'hF;
      key_return_reset_enable_pin <= 1'b1; cyc(5);
      // key return reset: osc start plus fixed 2^17 reset wait
      key_fall(); wait_cpu();
      w = osc_start_cycles + (1 << (reset_wait_exp_long - scale));
      `CHK(n >= w && n <= w + 20, 1'b1)
      key_input_pin <= 4'hF; cyc(5);
      `CHK({rst_seen > 0, key_return_flag, watchdog_flag}, 3'b111)
      key_return_reset_enable_pin <= 1'b0;
      $display("test stop key done");
      // interrupt release of stop for every legal wait code
      noise_filter_bypass_bit <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         bus(1, addr_irq_enable, 0);
         bus(1, addr_irq_request, 32'hF);
         bus(1, addr_irq_enable, 32'h2);
         bus(1, addr_wait_select, codes[i] | (($urandom % 2) << 3));
         stop_exec <= 1'b1; @(posedge mclk); stop_exec <= 1'b0; cyc(5);
         external_irq_zero <= 1'b0; @(posedge mclk); wait_cpu();
         w = osc_start_cycles + wait_cycles(3'(codes[i]));
         `CHK(n >= w && n <= w + 12, 1'b1)
         bus(0, addr_irq_request, 0); `CHK(rd[1], 1'b1)
         `CHK(osc_enable, 1'b1)
         external_irq_zero <= 1'b1; cyc(3);
      end
      $display("test stop irq done");
      // pending enabled request at entry: wait select time, no osc start
      bus(1, addr_irq_enable, 0);
      bus(1, addr_irq_request, 32'hF);
      bus(1, addr_irq_enable, 32'h1);
      timer_tick <= 1'b1; @(posedge mclk); timer_tick <= 1'b0; cyc(3);
      stop_exec <= 1'b1;
      @(posedge mclk);
      stop_exec <= 1'b0;
      // cpu enable drops one edge after the state change
      cyc(2);
      wait_cpu();
      w = wait_cycles(3'h7);
      `CHK(n >= w && n < w + osc_start_cycles, 1'b1)
      $display("test pending done");
      nrst <= 1'b0; cyc(2); nrst <= 1'b1; cyc(2);
      `CHK({key_return_flag, watchdog_flag}, 2'b00)
      $display("test reset done");
      stop_test();
   end
endmodule
